// ===== rtl/gsma_top.sv
// graphics sdram module: command decode, two-bank array, bursts, straps, presence store
`timescale 1ns/100ps
module gsma_top
  import gsma_pkg::*;
#(
  parameter int                  ROWS_W    = ROW_W,
  parameter int                  COLS_W    = COL_W,
  parameter gsma_pkg::gsma_freq_t FREQ_CODE = gsma_pkg::FREQ_125
) (
  // clock and reset
  input  wire logic                       CLK_SYS,
  input  wire logic                       RESET,
  // command and address
  input  wire logic                       CKE,
  input  wire logic                       CS_N,
  input  wire logic                       RAS_N,
  input  wire logic                       CAS_N,
  input  wire logic                       WE_N,
  input  wire logic                       DSF,
  input  wire logic                       BA,
  input  wire logic [8:0]                 ADDR,
  input  wire logic [gsma_pkg::BYTE_LANES-1:0] DQM,
  // data pins
  input  wire logic [gsma_pkg::DQ_W-1:0]  DQ_IN,
  output logic      [gsma_pkg::DQ_W-1:0]  DQ_OUT,
  output logic                            DQ_OE_N,
  output logic                            RD_VALID,
  input  wire logic                       RD_READY,
  // frequency straps
  output logic                            FREQ_STRAP_BIT2,
  output logic                            FREQ_STRAP_BIT1,
  output logic                            FREQ_STRAP_BIT0,
  // presence-detect bus
  input  wire logic                       PRESENCE_ADDR_STRAP,
  input  wire logic                       SCL_IN,
  input  wire logic                       SDA_IN,
  output logic                            SDA_OUT,
  output logic                            SDA_OE_N
);
  import gsma_pkg::*;

  localparam int AW = 1 + ROWS_W + COLS_W;

  function automatic logic [COLS_W-1:0] burst_col(input logic [COLS_W-1:0] start,
                                                  input logic [COLS_W:0]   idx,
                                                  input logic [2:0]        bl,
                                                  input logic              ilv);
    logic [COLS_W-1:0] msk;
    logic [COLS_W-1:0] off;
    msk = (bl == BL_PAGE) ? {COLS_W{1'b1}} : ~({COLS_W{1'b1}} << bl[1:0]);
    off = idx[COLS_W-1:0];
    if (ilv && bl != BL_PAGE) begin
      return (start & ~msk) | ((start ^ off) & msk);
    end
    return (start & ~msk) | ((start + off) & msk);
  endfunction

  // reserved length codes run a full page of beats; their columns wrap as for codes 0 to 2
  function automatic logic [COLS_W:0] burst_len(input logic [2:0] bl);
    if (bl[2]) begin
      return (COLS_W+1)'(1) << COLS_W;
    end
    return (COLS_W+1)'(1) << bl[1:0];
  endfunction

  function automatic logic [DQ_W-1:0] lane_en(input logic [BYTE_LANES-1:0] dqm);
    logic [DQ_W-1:0] en;
    en = '0;
    for (int i = 0; i < BYTE_LANES; i++) begin
      en[i*8 +: 8] = {8{~dqm[i]}};
    end
    return en;
  endfunction

  function automatic logic [DQ_W-1:0] merge(input logic [DQ_W-1:0] old,
                                            input logic [DQ_W-1:0] data,
                                            input logic [DQ_W-1:0] en);
    return (old & ~en) | (data & en);
  endfunction

  // command decode
  gsma_cmd_t cmd;
  logic      cmd_ok;
  logic      is_act;
  logic      is_pre;
  logic      is_rd;
  logic      is_wr;
  logic      is_blk;
  logic      is_mode;
  logic      is_term;

  // bank, mode and burst state
  logic [ROWS_W-1:0] row_reg [0:1];
  logic [1:0]        open_reg;
  logic [1:0]        wpb_reg;
  logic [MODE_W-1:0] mode_reg;
  logic [DQ_W-1:0]   color_reg;
  logic [DQ_W-1:0]   bitmask_reg;
  gsma_burst_t       burst_reg;
  logic              b_bank_reg;
  logic [ROWS_W-1:0] b_row_reg;
  logic [COLS_W-1:0] b_start_reg;
  logic [COLS_W:0]   b_idx_reg;
  logic              b_ap_reg;
  logic              b_wpb_reg;
  logic [2:0]        bl;
  logic              ilv;
  logic [COLS_W:0]   len;
  logic              stall;
  logic              adv;
  logic              last_beat;
  logic              ap_fire;
  logic              ap_bank;

  // array access
  logic [DQ_W-1:0]   mem [0:(2**AW)-1];
  logic              wr_en;
  logic [AW-1:0]     wr_addr;
  logic [DQ_W-1:0]   wr_mask;
  logic [AW-1:0]     rd_addr;

  // read fifo
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [DQ_W-1:0]   fifo_out_data;

  // presence-detect bus
  gsma_i2c_t         i2c_reg;
  logic              scl_reg;
  logic              sda_reg;
  logic [3:0]        bit_cnt_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        ptr_reg;
  logic              rw_reg;
  logic              addr_seen_reg;
  logic [7:0]        spd_mem [0:SPD_BYTES-1];
  logic              scl_rise;
  logic              scl_fall;
  logic              i2c_start;
  logic              i2c_stop;

  assign cmd     = gsma_cmd_t'({RAS_N, CAS_N, WE_N});
  assign cmd_ok  = CKE & ~CS_N;
  assign is_act  = cmd_ok && cmd == CMD_ACT;
  assign is_pre  = cmd_ok && cmd == CMD_PRE;
  // column commands to a closed bank are ignored
  assign is_rd   = cmd_ok && cmd == CMD_READ && open_reg[BA];
  assign is_wr   = cmd_ok && cmd == CMD_WRITE && open_reg[BA] && !DSF;
  assign is_blk  = cmd_ok && cmd == CMD_WRITE && open_reg[BA] && DSF;
  assign is_mode = cmd_ok && cmd == CMD_MODE;
  assign is_term = cmd_ok && cmd == CMD_TERM;

  assign bl  = mode_reg[MODE_BL_LSB +: 3];
  assign ilv = mode_reg[MODE_BT_BIT];
  assign len = burst_len(bl);

  // a full read fifo freezes the burst rather than dropping words
  assign stall     = (burst_reg == B_READ) && !fifo_in_ready;
  // clock enable low is power-down: burst frozen; flops need no refresh
  assign adv       = CKE && !stall;
  assign last_beat = (burst_reg != B_IDLE) && adv && (b_idx_reg == len - 1'b1);

  // close after final beat; single-beat writes close on the command itself
  always_comb begin
    ap_fire = 1'b0;
    ap_bank = b_bank_reg;
    if ((is_wr && len == (COLS_W+1)'(1)) || is_blk) begin
      ap_fire = ADDR[AP_BIT];
      ap_bank = BA;
    end else if (last_beat && b_ap_reg && !is_rd && !is_wr) begin
      ap_fire = 1'b1;
    end
  end

  // bank rows; the other bank may be precharged during a burst
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      row_reg[0] <= '0;
      row_reg[1] <= '0;
      open_reg   <= 2'h0;
      wpb_reg    <= 2'h0;
    end else begin
      if (is_act) begin
        open_reg[BA] <= 1'b1;
        row_reg[BA]  <= ADDR[ROWS_W-1:0];
        wpb_reg[BA]  <= DSF;
      end else if (is_pre) begin
        if (ADDR[AP_BIT]) begin
          open_reg <= 2'h0;
        end else begin
          open_reg[BA] <= 1'b0;
        end
      end
      if (ap_fire && !(is_act && BA == ap_bank)) begin
        open_reg[ap_bank] <= 1'b0;
      end
    end
  end

  // mode word and the colour and bit-mask loads of the special mode set
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      mode_reg    <= MODE_RESET;
      color_reg   <= '0;
      bitmask_reg <= '1;
    end else if (is_mode) begin
      if (!DSF) begin
        mode_reg <= ADDR;
      end else begin
        if (ADDR[SPEC_COLOR_BIT]) begin
          color_reg <= DQ_IN;
        end
        if (ADDR[SPEC_MASK_BIT]) begin
          bitmask_reg <= DQ_IN;
        end
      end
    end
  end

  // burst sequencer; a new read or write restarts it, a block write ends it
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      burst_reg   <= B_IDLE;
      b_bank_reg  <= 1'b0;
      b_row_reg   <= '0;
      b_start_reg <= '0;
      b_idx_reg   <= '0;
      b_ap_reg    <= 1'b0;
      b_wpb_reg   <= 1'b0;
    end else if (is_rd || is_wr) begin
      b_bank_reg  <= BA;
      b_row_reg   <= row_reg[BA];
      b_start_reg <= ADDR[COLS_W-1:0];
      b_ap_reg    <= ADDR[AP_BIT];
      b_wpb_reg   <= wpb_reg[BA];
      if (is_rd) begin
        burst_reg <= B_READ;
        b_idx_reg <= '0;
      end else begin
        burst_reg <= (len == (COLS_W+1)'(1)) ? B_IDLE : B_WRITE;
        b_idx_reg <= (COLS_W+1)'(1);
      end
    end else if (is_term || is_blk) begin
      burst_reg <= B_IDLE;
    end else if (last_beat) begin
      burst_reg <= B_IDLE;
    end else if (burst_reg != B_IDLE && adv) begin
      b_idx_reg <= b_idx_reg + 1'b1;
    end
  end

  // write port: first beat rides with the command, later beats from the sequencer
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = {b_bank_reg, b_row_reg, burst_col(b_start_reg, b_idx_reg, bl, ilv)};
    wr_mask = lane_en(DQM);
    if (is_wr) begin
      wr_en   = 1'b1;
      wr_addr = {BA, row_reg[BA], burst_col(ADDR[COLS_W-1:0], '0, bl, ilv)};
      if (wpb_reg[BA]) begin
        wr_mask = lane_en(DQM) & bitmask_reg;
      end
    end else if (burst_reg == B_WRITE && CKE) begin
      wr_en = 1'b1;
      if (b_wpb_reg) begin
        wr_mask = lane_en(DQM) & bitmask_reg;
      end
    end
  end

  // block write: low data bits pick which of the eight columns take the colour
  always_ff @(posedge CLK_SYS) begin
    if (wr_en) begin
      mem[wr_addr] <= merge(mem[wr_addr], DQ_IN, wr_mask);
    end else if (is_blk) begin
      for (int k = 0; k < BLOCK_COLS; k++) begin
        if (DQ_IN[k]) begin
          mem[{BA, row_reg[BA], ADDR[COLS_W-1:BLOCK_LSB], 3'(k)}] <=
            merge(mem[{BA, row_reg[BA], ADDR[COLS_W-1:BLOCK_LSB], 3'(k)}], color_reg,
                  wpb_reg[BA] ? (lane_en(DQM) & bitmask_reg) : lane_en(DQM));
        end
      end
    end
  end

  assign rd_addr       = {b_bank_reg, b_row_reg, burst_col(b_start_reg, b_idx_reg, bl, ilv)};
  assign fifo_in_valid = (burst_reg == B_READ) && CKE;

  gsma_fifo #(
    .WIDTH (DQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .clk       (CLK_SYS),
    .rst       (RESET),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (mem[rd_addr]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // output stage holds a word until the controller takes it
  assign fifo_out_ready = !RD_VALID || RD_READY;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      DQ_OUT   <= '0;
      RD_VALID <= 1'b0;
      DQ_OE_N  <= 1'b1;
    end else if (fifo_out_ready) begin
      DQ_OUT   <= fifo_out_data;
      RD_VALID <= fifo_out_valid;
      DQ_OE_N  <= ~fifo_out_valid;
    end
  end

  // straps are fixed by assembly, modelled by a build-time code
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      FREQ_STRAP_BIT2 <= FREQ_CODE[2];
      FREQ_STRAP_BIT1 <= FREQ_CODE[1];
      FREQ_STRAP_BIT0 <= FREQ_CODE[0];
      SDA_OUT         <= 1'b0;
    end else begin
      FREQ_STRAP_BIT2 <= FREQ_CODE[2];
      FREQ_STRAP_BIT1 <= FREQ_CODE[1];
      FREQ_STRAP_BIT0 <= FREQ_CODE[0];
      SDA_OUT         <= 1'b0;
    end
  end

  // presence-detect i2c slave; bus lines sampled once for edge detection
  assign scl_rise  = SCL_IN && !scl_reg;
  assign scl_fall  = !SCL_IN && scl_reg;
  assign i2c_start = SCL_IN && scl_reg && sda_reg && !SDA_IN;
  assign i2c_stop  = SCL_IN && scl_reg && !sda_reg && SDA_IN;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      scl_reg       <= 1'b1;
      sda_reg       <= 1'b1;
      i2c_reg       <= I_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      ptr_reg       <= 8'h00;
      rw_reg        <= 1'b0;
      addr_seen_reg <= 1'b0;
      SDA_OE_N      <= 1'b1;
      for (int i = 0; i < SPD_BYTES; i++) begin
        spd_mem[i] <= SPD_RESET;
      end
    end else begin
      scl_reg <= SCL_IN;
      sda_reg <= SDA_IN;
      if (i2c_start) begin
        i2c_reg       <= I_DEV;
        bit_cnt_reg   <= 4'h0;
        addr_seen_reg <= 1'b0;
        SDA_OE_N      <= 1'b1;
      end else if (i2c_stop) begin
        i2c_reg  <= I_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (scl_rise) begin
        if ((i2c_reg == I_DEV || i2c_reg == I_ADDR || i2c_reg == I_WDATA)
            && bit_cnt_reg != 4'h8) begin
          shift_reg   <= {shift_reg[6:0], SDA_IN};
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end else if (i2c_reg == I_RACK) begin
          i2c_reg <= SDA_IN ? I_IDLE : I_ACK;
        end
      end else if (scl_fall) begin
        unique case (i2c_reg)
          I_DEV: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == {SPD_DEV_PREFIX, PRESENCE_ADDR_STRAP}) begin
                rw_reg   <= shift_reg[0];
                SDA_OE_N <= 1'b0;
                i2c_reg  <= I_ACK;
              end else begin
                i2c_reg <= I_IDLE;
              end
            end
          end
          I_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              ptr_reg       <= shift_reg;
              addr_seen_reg <= 1'b1;
              SDA_OE_N      <= 1'b0;
              i2c_reg       <= I_ACK;
            end
          end
          I_WDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              spd_mem[ptr_reg] <= shift_reg;
              ptr_reg          <= ptr_reg + 1'b1;
              SDA_OE_N         <= 1'b0;
              i2c_reg          <= I_ACK;
            end
          end
          I_ACK: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              SDA_OE_N    <= spd_mem[ptr_reg][7];
              shift_reg   <= {spd_mem[ptr_reg][6:0], 1'b0};
              bit_cnt_reg <= 4'h1;
              ptr_reg     <= ptr_reg + 1'b1;
              i2c_reg     <= I_RDATA;
            end else begin
              SDA_OE_N <= 1'b1;
              i2c_reg  <= addr_seen_reg ? I_WDATA : I_ADDR;
            end
          end
          I_RDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              SDA_OE_N <= 1'b1;
              i2c_reg  <= I_RACK;
            end else begin
              SDA_OE_N    <= shift_reg[7];
              shift_reg   <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
          end
          I_IDLE, I_RACK: begin
            SDA_OE_N <= 1'b1;
          end
          default: begin
            i2c_reg  <= I_IDLE;
            SDA_OE_N <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ===== common/gsma_pkg.sv
// shared constants and types for the graphics sdram module access block
package gsma_pkg;
  // data path and array geometry
  localparam int DQ_W       = 64;
  localparam int BYTE_LANES = 8;
  localparam int ROW_W      = 9;
  localparam int COL_W      = 8;
  localparam int BLOCK_COLS = 8;
  localparam int BLOCK_LSB  = 3;
  localparam int FIFO_DEPTH = 8;

  // mode word fields, reset value
  localparam int         MODE_W      = 9;
  localparam int         MODE_BL_LSB = 0;
  localparam int         MODE_BT_BIT = 3;
  localparam logic [8:0] MODE_RESET  = 9'h000;
  localparam logic [2:0] BL_PAGE     = 3'h7;

  // address bits with a command-specific meaning
  localparam int AP_BIT         = 8;
  localparam int SPEC_COLOR_BIT = 5;
  localparam int SPEC_MASK_BIT  = 6;

  // presence-detect store
  localparam int         SPD_BYTES      = 256;
  localparam int         SPD_FACTORY    = 128;
  localparam logic [5:0] SPD_DEV_PREFIX = 6'h28;
  localparam logic [7:0] SPD_RESET      = 8'h00;

  // command code is {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_MODE  = 3'h0,
    CMD_REF   = 3'h1,
    CMD_PRE   = 3'h2,
    CMD_ACT   = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ  = 3'h5,
    CMD_TERM  = 3'h6,
    CMD_NOP   = 3'h7
  } gsma_cmd_t;

  typedef enum logic [2:0] {
    FREQ_83  = 3'h1,
    FREQ_100 = 3'h2,
    FREQ_125 = 3'h3
  } gsma_freq_t;

  typedef enum logic [1:0] {
    B_IDLE  = 2'h0,
    B_READ  = 2'h1,
    B_WRITE = 2'h2
  } gsma_burst_t;

  typedef enum logic [2:0] {
    I_IDLE  = 3'h0,
    I_DEV   = 3'h1,
    I_ADDR  = 3'h2,
    I_WDATA = 3'h3,
    I_ACK   = 3'h4,
    I_RDATA = 3'h5,
    I_RACK  = 3'h6
  } gsma_i2c_t;
endpackage

// ===== rtl/gsma_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module gsma_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = store[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer wrap written out so non-power-of-two depths also work
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data;
    end
  end
endmodule

// ===== verification/gsma_chk.sv
// port assertions for the graphics sdram module
`timescale 1ns/100ps
module gsma_chk
  import gsma_pkg::*;
#(
  parameter gsma_freq_t FREQ_CODE = FREQ_125
) (
  // clock and reset
  input wire logic            CLK_SYS,
  input wire logic            RESET,
  // read path
  input wire logic            RD_VALID,
  input wire logic            RD_READY,
  input wire logic            DQ_OE_N,
  input wire logic [DQ_W-1:0] DQ_OUT,
  // straps and presence bus
  input wire logic            FREQ_STRAP_BIT2,
  input wire logic            FREQ_STRAP_BIT1,
  input wire logic            FREQ_STRAP_BIT0,
  input wire logic            SCL_IN,
  input wire logic            SDA_IN,
  input wire logic            SDA_OUT,
  input wire logic            SDA_OE_N
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_strap_code:
    assert property ({FREQ_STRAP_BIT2, FREQ_STRAP_BIT1, FREQ_STRAP_BIT0} == FREQ_CODE)
    else $error("strap code wrong");
  a_sda_low:
    assert property (SDA_OUT == 1'b0) else $error("sda data not low");
  a_oe_tracks:
    assert property (DQ_OE_N == !RD_VALID) else $error("enable and valid disagree");
  a_word_held:
    assert property (RD_VALID && !RD_READY |=> RD_VALID && $stable(DQ_OUT))
    else $error("word dropped while stalled");
  a_drop_taken:
    assert property ($fell(RD_VALID) |-> $past(RD_READY)) else $error("valid fell untaken");
  a_out_change:
    assert property ($changed(DQ_OUT) |-> $past(RD_READY) || !$past(RD_VALID))
    else $error("read data changed early");
  a_reset_quiet:
    assert property ($fell(RESET) |-> !RD_VALID && DQ_OE_N && SDA_OE_N)
    else $error("outputs busy after reset");
  a_bus_quiet:
    assert property ((SCL_IN && SDA_IN) [*3] |-> SDA_OE_N) else $error("ack on idle bus");

  c_stall: cover property (RD_VALID && !RD_READY);
  c_read: cover property ($rose(RD_VALID));
  c_taken: cover property (RD_VALID && RD_READY);
endmodule

bind gsma_top gsma_chk #(.FREQ_CODE(FREQ_CODE)) i_gsma_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
  .DQ_OE_N(DQ_OE_N), .DQ_OUT(DQ_OUT), .FREQ_STRAP_BIT2(FREQ_STRAP_BIT2),
  .FREQ_STRAP_BIT1(FREQ_STRAP_BIT1), .FREQ_STRAP_BIT0(FREQ_STRAP_BIT0),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N));

// ===== verification/gsma_rd_sink.sv
// controller read side: takes words, stalls on request
`timescale 1ns/100ps
module gsma_rd_sink (
  // clock
  input wire logic        clk,
  // stall request
  input wire logic        stall,
  // read word handshake
  input wire logic        rd_valid,
  input wire logic [63:0] dq_out,
  output logic            rd_ready
);
  logic [63:0] q[$];
  assign rd_ready = !stall;
  // words count only at a rising edge with both high
  always @(posedge clk) begin
    if (rd_valid && rd_ready)
      q.push_back(dq_out);
  end
endmodule

// ===== verification/gsma_top_tb.sv
// self-checking bench for the graphics sdram module
`timescale 1ns/100ps
module gsma_top_tb;
  import gsma_pkg::*;
  logic        clk, rst, cke, cs_n, ras_n, cas_n, we_n, dsf, ba, stall;
  logic        oe_n, rd_valid, rd_ready, sda_out, sda_oe_n;
  logic        scl, sda_m, pas;
  // open-drain bus: either side may pull the line low
  wire         sda_line = sda_m & (sda_oe_n | sda_out);
  logic [2:0]  strap;
  logic [8:0]  addr;
  logic [7:0]  dqm;
  logic [63:0] dq_in, dq_out, a, b, c;
  int          num_errors = 0;
  int          checks = 0;

  // small array keeps the flop storage cheap
  gsma_top #(.ROWS_W(4), .COLS_W(4)) i_gsma_top (
    .CLK_SYS(clk), .RESET(rst), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n),
    .WE_N(we_n), .DSF(dsf), .BA(ba), .ADDR(addr), .DQM(dqm), .DQ_IN(dq_in),
    .DQ_OUT(dq_out), .DQ_OE_N(oe_n), .RD_VALID(rd_valid), .RD_READY(rd_ready),
    .FREQ_STRAP_BIT2(strap[2]), .FREQ_STRAP_BIT1(strap[1]), .FREQ_STRAP_BIT0(strap[0]),
    .PRESENCE_ADDR_STRAP(pas), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n));
  gsma_rd_sink i_gsma_rd_sink (.clk(clk), .stall(stall), .rd_valid(rd_valid),
    .dq_out(dq_out), .rd_ready(rd_ready));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cmd(input logic [2:0] k, input logic bk, input logic [8:0] ad,
                     input logic [63:0] d, input logic [7:0] m, input logic s);
    @(posedge clk);
    {ras_n, cas_n, we_n} <= k;
    ba <= bk;
    addr <= ad;
    dq_in <= d;
    dqm <= m;
    dsf <= s;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // a missing word shows up as unknown
  task automatic take(input logic [63:0] exp);
    for (int i = 0; i < 20 && i_gsma_rd_sink.q.size() == 0; i++)
      @(negedge clk);
    chk(i_gsma_rd_sink.q.size() ? i_gsma_rd_sink.q.pop_front() : 64'hX, exp);
  endtask

  task automatic t_mask;
    a = 64'h1111_2222_3333_4444;
    b = 64'hAAAA_BBBB_CCCC_DDDD;
    cmd(CMD_ACT, 1'b0, 9'h001, '0, '0, 1'b0);
    cmd(CMD_WRITE, 1'b0, 9'h002, a, 8'h00, 1'b0);
    cmd(CMD_WRITE, 1'b0, 9'h002, b, 8'h0F, 1'b0);
    cmd(CMD_READ, 1'b0, 9'h002, '0, '0, 1'b0);
    cmd(CMD_NOP, 1'b0, 9'h000, '0, '0, 1'b0);
    take({b[63:32], a[31:0]});
    cmd(CMD_PRE, 1'b0, 9'h000, '0, '0, 1'b0);
    cmd(CMD_ACT, 1'b0, 9'h003, '0, '0, 1'b1);
    cmd(CMD_WRITE, 1'b0, 9'h002, a, 8'h00, 1'b0);
    cmd(CMD_MODE, 1'b0, 9'h040, 64'h0000_FFFF_0000_FFFF, '0, 1'b1);
    cmd(CMD_WRITE, 1'b0, 9'h002, b, 8'h01, 1'b0);
    cmd(CMD_MODE, 1'b0, 9'h040, '1, '0, 1'b1);
    cmd(CMD_READ, 1'b0, 9'h002, '0, '0, 1'b0);
    cmd(CMD_NOP, 1'b0, 9'h000, '0, '0, 1'b0);
    take(64'h1111_BBBB_3333_DD44);
  endtask

  task automatic t_burst;
    int e[8] = '{2, 3, 0, 1, 1, 0, 3, 2};
    cmd(CMD_MODE, 1'b0, 9'h002, '0, '0, 1'b0);
    cmd(CMD_WRITE, 1'b0, 9'h004, 64'h0, '0, 1'b0);
    for (int i = 1; i < 4; i++)
      cmd(CMD_NOP, 1'b0, 9'h000, 64'(i), '0, 1'b0);
    stall <= 1'b1;
    cmd(CMD_READ, 1'b0, 9'h006, '0, '0, 1'b0);
    cmd(CMD_NOP, 1'b0, 9'h000, '0, '0, 1'b0);
    repeat (6) @(posedge clk);
    stall <= 1'b0;
    for (int i = 0; i < 4; i++)
      take(64'(e[i]));
    cmd(CMD_MODE, 1'b0, 9'h00A, '0, '0, 1'b0);
    cmd(CMD_READ, 1'b0, 9'h005, '0, '0, 1'b0);
    cmd(CMD_NOP, 1'b0, 9'h000, '0, '0, 1'b0);
    for (int i = 4; i < 8; i++)
      take(64'(e[i]));
    // length 8 from column 4, frozen two cycles, then cut after three words
    cmd(CMD_MODE, 1'b0, 9'h003, '0, '0, 1'b0);
    cmd(CMD_READ, 1'b0, 9'h004, '0, '0, 1'b0);
    cmd(CMD_NOP, 1'b0, 9'h000, '0, '0, 1'b0);
    cmd(CMD_TERM, 1'b0, 9'h000, '0, '0, 1'b0);
    cke <= 1'b0;
    cmd(CMD_TERM, 1'b0, 9'h000, '0, '0, 1'b0);
    cmd(CMD_NOP, 1'b0, 9'h000, '0, '0, 1'b0);
    cke <= 1'b1;
    cmd(CMD_TERM, 1'b0, 9'h000, '0, '0, 1'b0);
    cmd(CMD_NOP, 1'b0, 9'h000, '0, '0, 1'b0);
    for (int i = 0; i < 3; i++)
      take(64'(i));
    repeat (10) @(negedge clk);
    chk(64'(i_gsma_rd_sink.q.size()), 64'h0);
  endtask

  task automatic t_block;
    c = 64'h5A5A_0F0F_A5A5_F0F0;
    cmd(CMD_MODE, 1'b0, 9'h020, c, '0, 1'b1);
    cmd(CMD_MODE, 1'b0, 9'h000, '0, '0, 1'b0);
    cmd(CMD_ACT, 1'b1, 9'h002, '0, '0, 1'b0);
    cmd(CMD_PRE, 1'b0, 9'h000, '0, '0, 1'b0);
    cmd(CMD_WRITE, 1'b1, 9'h009, a, '0, 1'b0);
    cmd(CMD_WRITE, 1'b1, 9'h008, 64'h81, '0, 1'b1);
    cmd(CMD_READ, 1'b1, 9'h00F, '0, '0, 1'b0);
    cmd(CMD_READ, 1'b1, 9'h009, '0, '0, 1'b0);
    cmd(CMD_READ, 1'b1, 9'h108, '0, '0, 1'b0);
    cmd(CMD_NOP, 1'b0, 9'h000, '0, '0, 1'b0);
    cmd(CMD_READ, 1'b1, 9'h008, '0, '0, 1'b0);
    cmd(CMD_READ, 1'b0, 9'h002, '0, '0, 1'b0);
    cmd(CMD_NOP, 1'b0, 9'h000, '0, '0, 1'b0);
    take(c);
    take(a);
    take(c);
    repeat (10) @(negedge clk);
    chk(64'(i_gsma_rd_sink.q.size()), 64'h0);
  endtask

  task automatic i2c_bit(input logic v, output logic r);
    sda_m <= v;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    r = sda_line;
    scl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic i2c_start;
    sda_m <= 1'b1;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    sda_m <= 1'b0;
    repeat (2) @(posedge clk);
    scl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic i2c_stop;
    sda_m <= 1'b0;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    sda_m <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic i2c_byte(input logic [7:0] v, output logic [7:0] r);
    logic k;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(v[i], k);
      r[i] = k;
    end
  endtask

  task automatic i2c_wr(input logic [7:0] v, input logic ack);
    logic [7:0] r;
    logic       k;
    i2c_byte(v, r);
    i2c_bit(1'b1, k);
    chk(64'(k), 64'(ack));
  endtask

  // wrong address ignored, strap moves it; user byte written and read back
  task automatic t_spd;
    logic [7:0] r;
    logic       k;
    @(posedge clk);
    i2c_start();
    i2c_wr(8'hA2, 1'b1);
    pas <= 1'b1;
    i2c_start();
    i2c_wr(8'hA2, 1'b0);
    pas <= 1'b0;
    i2c_start();
    i2c_wr(8'hA0, 1'b0);
    i2c_wr(8'h83, 1'b0);
    i2c_wr(8'h5C, 1'b0);
    i2c_start();
    i2c_wr(8'hA0, 1'b0);
    i2c_wr(8'h83, 1'b0);
    i2c_start();
    i2c_wr(8'hA1, 1'b0);
    i2c_byte(8'hFF, r);
    i2c_bit(1'b1, k);
    i2c_stop();
    chk(64'(r), 64'h5C);
  endtask

  task automatic results;
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    rst = 1'b1;
    cke = 1'b1;
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = 3'h7;
    {dsf, ba, stall} = 3'h0;
    {scl, sda_m, pas} = 3'h6;
    addr = '0;
    dqm = '0;
    dq_in = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk(64'(strap), 64'(FREQ_125));
    t_mask();
    t_burst();
    t_block();
    t_spd();
    results();
  end
endmodule
